// ### dv/drvf_host_model.sv
// Host bus model: drives one access at a time and captures the answer.
`timescale 1ns/1ps
module drvf_host_model (
  // Clock.
  input wire logic i_ref_clk,
  // Access request from the bench.
  input wire logic i_go,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  // Device answers.
  input wire logic [15:0] i_ctl,
  input wire logic [7:0] i_data,
  input wire logic i_oe_n,
  // Host pins and captured results.
  output drvf_pkg::drvf_host_t o_host,
  output logic o_done,
  output logic [15:0] o_ctl,
  output logic [7:0] o_rdata,
  output logic o_rd_oe_n
);
  logic [3:0] cnt_q;

  // Pins start off the video memory window.
  initial begin
    o_host = '{16'h8000, 1'b1, 8'h00};
    cnt_q = 4'h0;
    o_done = 1'b0;
    o_ctl = 16'h0000;
    o_rdata = 8'h00;
    o_rd_oe_n = 1'b1;
  end

  // Pins are held eight cycles; controls are taken mid-access, data last.
  // On release the address and data pins invert and read goes high so that stale values never look valid.
  always @(posedge i_ref_clk) begin
    o_done <= !i_go && cnt_q == 4'h1;
    if (i_go) begin
      o_host <= '{i_addr, i_rd, i_wdata};
      cnt_q <= 4'h8;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
      if (cnt_q == 4'h4) o_ctl <= i_ctl;
      if (cnt_q == 4'h1) begin
        o_rdata <= i_data;
        o_rd_oe_n <= i_oe_n;
        o_host <= '{~o_host.addr, 1'b1, ~o_host.wdata};
      end
    end
  end
endmodule : drvf_host_model

// ### dv/drvf_top_tb.sv
// Self-checking bench for the double rate video fetch.
`timescale 1ns/1ps
module drvf_top_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic rd = 1'b1;
  logic scan_rst_n = 1'b1;
  logic half_sel = 1'b0;
  logic [15:0] addr = 16'h8000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] hdata = 8'h00;
  // Horizontal values are halved, so the column count stays even.
  drvf_pkg::drvf_fmt_t fmt = '{10'h000, 10'h001, 8'h03,
    8'h02, 4'h0, 5'h01};
  drvf_pkg::drvf_host_t host;
  logic [1:0] cs_n, xen_n;
  logic [9:0] baddr, ma;
  logic [3:0] ra;
  logic [7:0] hout, code, rdata, last_ev;
  logic oe_n, we_n, to_host, ck8, ck16, de, load, ev, od, cur, done, rd_oe_n;
  logic [15:0] ctl;
  logic [7:0] mem [2048];
  logic [15:0] alist [12];
  logic [4:0] nd [4] = '{5'h1f, 5'h0e, 5'h07, 5'h17};
  logic [31:0] seed = 32'd19114;
  int n_fail = 0;
  int cmp_count = 0;
  int n8, n16, nld, ne, ncur;

  always #2.5 clk = ~clk;

  drvf_top i_dut (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_host(host), .i_host_data(hdata),
    .o_host_data(hout), .o_host_data_oe_n(oe_n),
    .i_scan_reset_n(scan_rst_n), .i_cursor_half_select(half_sel),
    .i_fmt(fmt), .o_bank_cs_n(cs_n), .o_bank_addr(baddr),
    .o_bank_we_n(we_n), .o_xcvr_en_n(xen_n), .o_xcvr_to_host(to_host),
    .o_char_clock(ck8), .o_controller_char_clock(ck16),
    .o_scan_memory_address(ma), .o_raster_row_address(ra),
    .o_display_enable(de), .o_load_strobe(load), .o_even_sel(ev),
    .o_odd_sel(od), .o_chargen_code(code), .o_cursor(cur));

  drvf_host_model i_host (
    .i_ref_clk(clk), .i_go(go), .i_addr(addr), .i_rd(rd), .i_wdata(wdata),
    .i_ctl({cs_n, we_n, xen_n, to_host, baddr}), .i_data(hout),
    .i_oe_n(oe_n), .o_host(host), .o_done(done), .o_ctl(ctl),
    .o_rdata(rdata), .o_rd_oe_n(rd_oe_n));

  // Xorshift source with a fixed seed.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected bank controls and address during a decoded host access.
  function automatic logic [15:0] exp_ctl(input logic [15:0] a,
                                          input logic r);
    return {~a[0], a[0], r, ~a[0], a[0], r, a[10:1]};
  endfunction : exp_ctl

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("Counts: %0d compared, %0d wrong", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // One host access through the model, then its controls and data.
  task automatic access(input logic [15:0] a, input logic r,
                        input logic [7:0] d);
    logic dec;
    logic [31:0] x;
    dec = a[15:11] == 5'h0f;
    x = rnd();
    @(posedge clk);
    addr <= a;
    rd <= r;
    wdata <= d;
    hdata <= x[7:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
    // A hung access counts once and skips its checks; the run still ends.
    if (done !== 1'b1) begin
      n_fail++;
      return;
    end
    if (dec) chk(ctl, exp_ctl(a, r));
    else chk(ctl & 16'hf800, 16'h3800);
    if (dec && !r) mem[a[10:0]] = d;
    if (r && dec) chk(16'({rd_oe_n, rdata}), 16'({1'b0, mem[a[10:0]]}));
    if (r && !dec) chk(16'(rd_oe_n), 16'h0001);
  endtask : access

  // Watches the character feed for n cycles and gathers counts.
  task automatic watch(input int n);
    logic p8, p16;
    // Start on a falling edge so the first sample is a settled value.
    @(negedge clk);
    for (int i = 0; i < n; i++) begin
      p8 = ck8;
      p16 = ck16;
      @(negedge clk);
      n8 += int'(ck8 === 1'b1 && p8 === 1'b0);
      n16 += int'(ck16 === 1'b1 && p16 === 1'b0);
      nld += int'(load === 1'b1);
      chk(16'(ev & od), 16'h0000);
      chk(16'(ev && code[7:4] == 4'h2 || od && code[7:4] == 4'h1), 16'h0);
      if (ev) last_ev = code;
      if (od && code[7:4] == 4'h2 && last_ev[7:4] == 4'h1) begin
        ne++;
        chk(16'(code[3:0]), 16'(last_ev[3:0]));
      end
      if (cur) begin
        ncur++;
        chk(16'(half_sel ? od : ev), 16'h0001);
      end
    end
  endtask : watch

  // Main sequence.
  initial begin
    logic [31:0] x;
    logic [9:0] ns;
    repeat (10) @(negedge clk);
    chk(16'({cs_n, xen_n, we_n, oe_n}), 16'h000f);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 12; k++) begin
      x = rnd();
      alist[k] = k < 2 ? 16'h7fff - 16'(k) : {5'h0f, x[10:0] | 11'h080};
      access(alist[k], 1'b0, x[23:16]);
    end
    for (int k = 0; k < 12; k++) access(alist[k], 1'b1, 8'h00);
    $display("host access test done");
    for (int k = 0; k < 4; k++) begin
      access({nd[k], alist[0][10:0]}, 1'b0, 8'h5a);
      access({nd[k], alist[0][10:0]}, 1'b1, 8'h00);
    end
    for (int k = 0; k < 12; k++) access(alist[k], 1'b1, 8'h00);
    $display("decode miss test done");
    for (int w = 0; w < 16; w++) begin
      access({5'h0f, 6'h00, w[3:0], 1'b0}, 1'b0, {4'h1, w[3:0]});
      access({5'h0f, 6'h00, w[3:0], 1'b1}, 1'b0, {4'h2, w[3:0]});
    end
    repeat (40) @(posedge clk);
    n8 = 0;
    n16 = 0;
    nld = 0;
    ne = 0;
    ncur = 0;
    watch(160);
    chk(16'(n8), 16'h0014);
    chk(16'(n16), 16'h000a);
    chk(16'(nld), 16'h000a);
    chk(16'(ne != 0 && ncur != 0), 16'h0001);
    @(posedge clk);
    half_sel <= 1'b1;
    repeat (8) @(posedge clk);
    ncur = 0;
    watch(160);
    chk(16'(ncur != 0), 16'h0001);
    $display("character feed test done");
    x = rnd();
    ns = 10'h002 + {7'h00, x[1:0], 1'b0};
    @(posedge clk);
    scan_rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    fmt.start_addr <= ns;
    repeat (36) @(posedge clk);
    @(negedge clk);
    chk(16'({ma, ra, de}), 16'h0000);
    @(posedge clk);
    scan_rst_n <= 1'b1;
    for (int i = 0; i < 12 && ma !== ns; i++) @(negedge clk);
    chk(16'(ma), 16'(ns));
    $display("scan reset test done");
    print_verdict();
  end
endmodule : drvf_top_tb

// ### hdl/drvf_bank.sv
// One bank of video memory, 1k by 8, synchronous read and write.
`timescale 1ns/1ps
module drvf_bank #(
  parameter int AW = drvf_pkg::BANK_AW,
  parameter int DW = drvf_pkg::DATA_W,
  parameter int DEPTH = drvf_pkg::BANK_DEPTH
) (
  // Clock.
  input wire logic i_ref_clk,
  // Memory controls, active low.
  input wire logic i_cs_n,
  input wire logic i_we_n,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  // Read data.
  output logic [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [DEPTH];

  // Writes need select and write low; any selected cycle reads.
  always_ff @(posedge i_ref_clk) begin
    if (!i_cs_n && !i_we_n) begin
      mem[i_addr] <= i_wdata;
    end
    if (!i_cs_n) begin
      o_rdata <= mem[i_addr];
    end
  end

endmodule : drvf_bank

// ### hdl/drvf_pkg.sv
// Package of constants and carrier types for the double rate video fetch.
package drvf_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int BANK_AW = 10;
  localparam int BANK_DEPTH = 1024;
  localparam int HOST_AW = 16;
  localparam int RA_W = 4;
  localparam int HCNT_W = 8;
  localparam int ROW_W = 5;

  // ----------------------------------------------------------------
  // Clock division and decode
  // ----------------------------------------------------------------
  localparam int DOTS_PER_CHAR = 8;
  localparam logic [2:0] DOT_LAST = 3'h7;
  localparam logic [4:0] VRAM_DECODE = 5'h0f;
  localparam int DEC_LSB = 11;
  localparam int DEC_MSB = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CS_N_RST = 2'h0;
  localparam logic [1:0] XCVR_N_RST = 2'h3;
  localparam logic [BANK_AW-1:0] ADDR_RST = 10'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // Host bus sample: address, read level and write data.
  typedef struct packed {
    logic [HOST_AW-1:0] addr;
    logic rd;
    logic [DATA_W-1:0] wdata;
  } drvf_host_t;

  // Display format, all horizontal values already halved by software.
  typedef struct packed {
    logic [BANK_AW-1:0] start_addr;
    logic [BANK_AW-1:0] cursor_addr;
    logic [HCNT_W-1:0] h_total;
    logic [HCNT_W-1:0] h_disp;
    logic [RA_W-1:0] ra_last;
    logic [ROW_W-1:0] row_last;
  } drvf_fmt_t;

endpackage : drvf_pkg

// ### hdl/drvf_top.sv
// Double rate video fetch: bank control, clock division, scan and output.
//
// Overview of operation
// - Video memory is two banks: even character positions and odd ones.
// - Each bank holds 1k bytes, 2k bytes in total, enough for 80x24.
// - Scan address drives both banks together, one count reads both.
// - Host bits 10..1 address the banks; host bit 0 picks one bank.
// - Scanner sees 1k by 16 memory; host sees 2k by 8.
// - Without a host decode both bank selects stay low.
// - On decode only the bank chosen by bit 0 is selected.
// - On decode the bank address switches at once to the host.
// - Bank write follows host read/write only during decode.
// - Decode matches with bit 15 low and bits 14..11 high.
// - On decode only the chosen bank's transceiver is enabled.
// - Without decode both transceivers are off, host bus isolated.
// - Transceiver direction follows host read/write.
// - Dot clock divides by eight to form the character clock.
// - Character clock halves again to the controller clock.
// - Load strobe latches both banks; even and odd selects alternate.
// - Cursor is gated by odd select if half bit is 1, else even.
// - Scan reset low clears counters and drives scan outputs low.
// - Format may change during scan reset; release restarts with it.
`timescale 1ns/1ps
module drvf_top (
  // Clock (dot clock) and reset.
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Host bus pins.
  input wire drvf_pkg::drvf_host_t i_host,
  input wire logic [drvf_pkg::DATA_W-1:0] i_host_data,
  output logic [drvf_pkg::DATA_W-1:0] o_host_data,
  output logic o_host_data_oe_n,
  // Display control pins.
  input wire logic i_scan_reset_n,
  input wire logic i_cursor_half_select,
  input wire drvf_pkg::drvf_fmt_t i_fmt,
  // Bank control, visible for the board.
  output logic [1:0] o_bank_cs_n,
  output logic [drvf_pkg::BANK_AW-1:0] o_bank_addr,
  output logic o_bank_we_n,
  output logic [1:0] o_xcvr_en_n,
  output logic o_xcvr_to_host,
  // Clocks derived from the dot clock.
  output logic o_char_clock,
  output logic o_controller_char_clock,
  // Scan outputs.
  output logic [drvf_pkg::BANK_AW-1:0] o_scan_memory_address,
  output logic [drvf_pkg::RA_W-1:0] o_raster_row_address,
  output logic o_display_enable,
  // Character generator feed.
  output logic o_load_strobe,
  output logic o_even_sel,
  output logic o_odd_sel,
  output logic [drvf_pkg::DATA_W-1:0] o_chargen_code,
  output logic o_cursor
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  drvf_pkg::drvf_host_t host_m, host_s;
  drvf_pkg::drvf_fmt_t fmt_m, fmt_s;
  logic [1:0] pin_m, pin_s;
  logic scan_rst_s;
  logic half_s;

  // Two flops on every pin before any logic reads it, except i_rst_n, which logic reads directly, and i_host_data, which no logic reads.
  always_ff @(posedge i_ref_clk) begin
    host_m <= i_host;
    host_s <= host_m;
    fmt_m <= i_fmt;
    fmt_s <= fmt_m;
    pin_m <= {i_scan_reset_n, i_cursor_half_select};
    pin_s <= pin_m;
  end
  assign scan_rst_s = pin_s[1];
  assign half_s = pin_s[0];

  // ----------------------------------------------------------------
  // Host decode and bank control
  // ----------------------------------------------------------------
  logic match_s;
  logic odd_s;
  logic [1:0] one_n;
  logic [1:0] cs_n_d;
  logic [drvf_pkg::BANK_AW-1:0] addr_d;
  logic [drvf_pkg::DATA_W-1:0] wdata_q;
  logic [drvf_pkg::BANK_AW-1:0] ma_q;
  logic [drvf_pkg::DATA_W-1:0] bank_rd [2];

  // Decode of the five top host bits selects video memory.
  assign match_s = host_s.addr[drvf_pkg::DEC_MSB:drvf_pkg::DEC_LSB]
                   == drvf_pkg::VRAM_DECODE;
  assign odd_s = host_s.addr[0];
  assign one_n = odd_s ? 2'h1 : 2'h2;
  assign cs_n_d = match_s ? one_n : drvf_pkg::CS_N_RST;
  assign addr_d = match_s ? host_s.addr[drvf_pkg::BANK_AW:1] : ma_q;

  // Bank selects, address, write and transceivers settle together.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_bank_cs_n <= drvf_pkg::CS_N_RST;
      o_bank_addr <= drvf_pkg::ADDR_RST;
      o_bank_we_n <= 1'b1;
      o_xcvr_en_n <= drvf_pkg::XCVR_N_RST;
      o_xcvr_to_host <= 1'b1;
      wdata_q <= drvf_pkg::DATA_RST;
    end else begin
      o_bank_cs_n <= cs_n_d;
      o_bank_addr <= addr_d;
      o_bank_we_n <= !(match_s && !host_s.rd);
      o_xcvr_en_n <= match_s ? one_n : drvf_pkg::XCVR_N_RST;
      o_xcvr_to_host <= host_s.rd;
      wdata_q <= host_s.wdata;
    end
  end

  // Two banks, even at index 0 and odd at index 1.
  for (genvar b = 0; b < 2; b++) begin : g_bank
    drvf_bank u_bank (
      .i_ref_clk(i_ref_clk),
      .i_cs_n(o_bank_cs_n[b]),
      .i_we_n(o_bank_we_n),
      .i_addr(o_bank_addr),
      .i_wdata(wdata_q),
      .o_rdata(bank_rd[b])
    );
  end

  // Host read data leaves only through the enabled transceiver.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_host_data <= drvf_pkg::DATA_RST;
      o_host_data_oe_n <= 1'b1;
    end else begin
      o_host_data <= o_xcvr_en_n[0] ? bank_rd[1] : bank_rd[0];
      o_host_data_oe_n <= &o_xcvr_en_n || !o_xcvr_to_host;
    end
  end

  // ----------------------------------------------------------------
  // Clock division
  // ----------------------------------------------------------------
  logic [2:0] dot_q;
  logic phase_q;
  logic char_tick;
  logic controller_char_clock_tick;

  assign char_tick = dot_q == drvf_pkg::DOT_LAST;
  assign controller_char_clock_tick = char_tick && phase_q;

  // Eight dots per character, two characters per controller clock.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      dot_q <= 3'h0;
      phase_q <= 1'b0;
    end else begin
      dot_q <= dot_q + 3'h1;
      phase_q <= phase_q ^ char_tick;
    end
  end
  assign o_char_clock = dot_q[2];
  assign o_controller_char_clock = phase_q;

  // ----------------------------------------------------------------
  // Scan counters, one step per controller clock
  // ----------------------------------------------------------------
  logic run_q;
  logic [drvf_pkg::HCNT_W-1:0] h_q;
  logic [drvf_pkg::RA_W-1:0] ra_q;
  logic [drvf_pkg::ROW_W-1:0] row_q;
  logic [drvf_pkg::BANK_AW-1:0] base_q;
  logic h_end, ra_end, row_end;
  logic [drvf_pkg::BANK_AW-1:0] base_d;
  logic [drvf_pkg::BANK_AW-1:0] next_row;
  logic de_d;

  assign h_end = h_q == fmt_s.h_total;
  assign ra_end = ra_q == fmt_s.ra_last;
  assign row_end = row_q == fmt_s.row_last;
  assign next_row = base_q + drvf_pkg::BANK_AW'(fmt_s.h_disp);
  assign base_d = !ra_end ? base_q : row_end ? fmt_s.start_addr : next_row;
  assign de_d = run_q && (h_q < fmt_s.h_disp);

  // Scan reset clears the counters; release loads the start address.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !scan_rst_s) begin
      run_q <= 1'b0;
      h_q <= '0;
      ra_q <= '0;
      row_q <= '0;
      base_q <= drvf_pkg::ADDR_RST;
      ma_q <= drvf_pkg::ADDR_RST;
    end else if (!run_q) begin
      run_q <= 1'b1;
      base_q <= fmt_s.start_addr;
      ma_q <= fmt_s.start_addr;
    end else if (controller_char_clock_tick) begin
      h_q <= h_end ? '0 : h_q + 1'b1;
      if (h_end) begin
        ra_q <= ra_end ? '0 : ra_q + 1'b1;
        row_q <= !ra_end ? row_q : row_end ? '0 : row_q + 1'b1;
        base_q <= base_d;
        ma_q <= base_d;
      end else begin
        ma_q <= ma_q + 1'b1;
      end
    end
  end
  assign o_scan_memory_address = ma_q;
  assign o_raster_row_address = ra_q;

  // ----------------------------------------------------------------
  // Holding latches and character generator feed
  // ----------------------------------------------------------------
  logic [drvf_pkg::DATA_W-1:0] even_lat_q, odd_lat_q;
  logic cur_lat_q, de_lat_q;
  logic cur_raw;

  // The controller cursor covers both characters of one address.
  assign cur_raw = de_d && (ma_q == fmt_s.cursor_addr);

  // One load per controller clock captures both banks at once.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      even_lat_q <= drvf_pkg::DATA_RST;
      odd_lat_q <= drvf_pkg::DATA_RST;
      cur_lat_q <= 1'b0;
      de_lat_q <= 1'b0;
      o_load_strobe <= 1'b0;
    end else begin
      o_load_strobe <= controller_char_clock_tick;
      if (controller_char_clock_tick) begin
        even_lat_q <= bank_rd[0];
        odd_lat_q <= bank_rd[1];
        cur_lat_q <= cur_raw;
        de_lat_q <= de_d;
      end
    end
  end

  // Even latch in the first character time, odd in the second.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_even_sel <= 1'b0;
      o_odd_sel <= 1'b0;
      o_chargen_code <= drvf_pkg::DATA_RST;
      o_cursor <= 1'b0;
      o_display_enable <= 1'b0;
    end else begin
      o_even_sel <= !phase_q;
      o_odd_sel <= phase_q;
      o_chargen_code <= phase_q ? odd_lat_q : even_lat_q;
      o_cursor <= cur_lat_q && (half_s ? phase_q : !phase_q);
      o_display_enable <= de_lat_q && scan_rst_s;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_cs_idle_both: assert property (!match_s |=> o_bank_cs_n == 2'h0)
    else $error("bank selects not both low while host idle");
  a_cs_one_bank: assert property (match_s |=>
    o_bank_cs_n == ($past(odd_s) ? 2'h1 : 2'h2))
    else $error("wrong bank selected on host decode");
  a_addr_host_mux: assert property (match_s |=>
    o_bank_addr == $past(host_s.addr[10:1]))
    else $error("bank address not taken from host");
  a_addr_scan_mux: assert property (!match_s |=>
    o_bank_addr == $past(ma_q))
    else $error("bank address not taken from scan");
  a_we_read_idle: assert property (!match_s |=> o_bank_we_n)
    else $error("write enabled without decode");
  a_xcvr_isolate: assert property (!match_s |=> o_xcvr_en_n == 2'h3)
    else $error("transceiver enabled without decode");
  a_xcvr_one_dir: assert property (match_s |=>
    o_xcvr_en_n == o_bank_cs_n && o_xcvr_to_host == $past(host_s.rd))
    else $error("transceiver select or direction wrong");
  a_char_div_eight: assert property (char_tick |=>
    !char_tick [*7] ##1 char_tick)
    else $error("character clock not dot clock over eight");
  a_controller_char_clock_half_rate: assert property (controller_char_clock_tick |->
    ##8 !controller_char_clock_tick ##8 controller_char_clock_tick)
    else $error("controller clock not character clock over two");
  a_scan_stop_low: assert property (!scan_rst_s |=>
    ma_q == 10'h000 && ra_q == 4'h0 && !run_q)
    else $error("scan counters running during scan reset");
  a_latch_load_pair: assert property (controller_char_clock_tick |=>
    even_lat_q === $past(bank_rd[0]) && odd_lat_q === $past(bank_rd[1]))
    else $error("holding latches did not load both banks");
  a_even_first_half: assert property (controller_char_clock_tick |=>
    ##1 o_even_sel [*8] ##1 o_odd_sel)
    else $error("even latch not first in controller period");
  a_cursor_one_char: assert property (o_cursor |->
    (o_odd_sel == $past(half_s)) && (o_even_sel == !$past(half_s)))
    else $error("cursor not trimmed to selected half");

endmodule : drvf_top
